// ---- src/ufdq_map.svh ----
// register offsets, field positions, reset values and timing counts for the frame/done-queue block
`ifndef UFDQ_MAP_SVH
`define UFDQ_MAP_SVH
`define UFDQ_DONE_HEAD_OFS 8'h30
`define UFDQ_FRAME_SPACING_OFS 8'h34
`define UFDQ_FRAME_COUNTDOWN_OFS 8'h38
`define UFDQ_DH_MSB 31
`define UFDQ_DH_LSB 4
`define UFDQ_FIT_BIT 31
`define UFDQ_FS_MAX_PACKET_BITS_MSB 30
`define UFDQ_FS_MAX_PACKET_BITS_LSB 16
`define UFDQ_FI_MSB 13
`define UFDQ_FI_LSB 0
`define UFDQ_FI_RESET 14'h2EDF
`define UFDQ_DONE_HEAD_MASK 32'hFFFFFFF0
`define UFDQ_FRAME_SPACING_MASK 32'hFFFF3FFF
`define UFDQ_BIT_TIME_NS 83
`define UFDQ_CLK_PERIOD_NS 20
`endif

// ---- src/ufdq_pkg.sv ----
// types shared by the frame/done-queue block
package ufdq_pkg;
  typedef enum logic [1:0] {
    UFDQ_IDLE = 2'b00,
    UFDQ_LINK = 2'b01,
    UFDQ_FLUSH = 2'b10
  } ufdq_state_e;
  // memory write request toward the system memory port
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic [31:0] data;
  } ufdq_memwr_s;
  // register access from the base-address decode
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } ufdq_regreq_s;
endpackage

// ---- src/ufdq_top.sv ----
// frame interval timing and done-queue head handling for a full-speed host controller
// Functional notes
// - on descriptor completion write current head into its next-descriptor link
// - then head becomes the address of that just-completed descriptor
// - head register clears to zero whenever it is flushed to shared area
// - head is written to the shared communication area on each flush_req seen while idle with no td_done
// - head occupies bits 31:4; bits 3:0 reserved, read zero
// - at every frame start load bits 30:16 into packet budget counter
// - budget counter shows bits one transaction may move without overrun
// - bits 13:0 give start-of-frame spacing in bit times
// - frame interval resets to 11999; all other bits reset zero
// - remaining counter decrements per bit time, reloads from interval after zero
// - at zero the interval toggle is copied into remaining toggle
// - entering operational state reloads remaining counter from interval
`timescale 1ns/10ps
`include "ufdq_map.svh"
module ufdq_top import ufdq_pkg::*; #(
  parameter int BIT_CYCLES = (`UFDQ_BIT_TIME_NS + `UFDQ_CLK_PERIOD_NS - 1) / `UFDQ_CLK_PERIOD_NS,
  parameter logic [31:0] SHARED_HEAD_ADDR = 32'h00000084
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire ufdq_regreq_s reg_req,
  output logic [31:0] reg_rdata,
  input wire logic operational_state,
  input wire logic td_done,
  input wire logic [31:0] td_addr,
  output logic td_ready,
  input wire logic flush_req,
  output ufdq_memwr_s mem_wr,
  input wire logic mem_ack,
  input wire logic [14:0] xact_bits,
  input wire logic xact_req,
  output logic xact_grant,
  output logic sof_pulse,
  output logic [14:0] budget_bits
);
  logic [27:0] done_queue_head_ptr_reg;
  logic interval_toggle_reg;
  logic [14:0] fs_max_packet_bits_reg;
  logic [13:0] frame_interval_bits_reg;
  logic [13:0] frame_remaining_count_reg;
  logic remaining_toggle_reg;
  logic [14:0] budget_reg;
  logic [7:0] bit_div_reg;
  logic oper_d_reg;
  logic sof_reg;
  ufdq_state_e state_reg;
  ufdq_memwr_s mem_reg;
  logic [31:0] pend_addr_reg;
  logic bit_tick;
  logic wr_head;
  logic wr_spacing;
  logic oper_rise;
  logic frame_zero;
  logic [31:0] spacing_word;
  logic [31:0] countdown_word;

  // bit time is rounded up to whole system clocks, so frames run slightly long
  // against the true bit rate; software trims the interval to compensate
  localparam logic [7:0] BIT_LAST = 8'(BIT_CYCLES - 1);

  function automatic logic [31:0] ufdq_head_word(input logic [27:0] ptr);
    ufdq_head_word = {ptr, 4'h0};
  endfunction

  function automatic logic [27:0] ufdq_head_field(input logic [31:0] word);
    ufdq_head_field = word[`UFDQ_DH_MSB:`UFDQ_DH_LSB];
  endfunction

  function automatic logic ufdq_write_hit(input ufdq_regreq_s req, input logic [7:0] ofs);
    ufdq_write_hit = req.wr && (req.addr == ofs);
  endfunction

  assign wr_head = ufdq_write_hit(reg_req, `UFDQ_DONE_HEAD_OFS);
  assign wr_spacing = ufdq_write_hit(reg_req, `UFDQ_FRAME_SPACING_OFS);
  assign bit_tick = (bit_div_reg == BIT_LAST);
  assign oper_rise = operational_state && !oper_d_reg;
  assign frame_zero = (frame_remaining_count_reg == 14'h0000);

  // bit-time strobe from the system clock
  // free-running, so the first frame after entry may end up to one bit time early
  always_ff @(posedge clock) begin
    if (!rst_n || bit_tick) begin
      bit_div_reg <= 8'h00;
    end else begin
      bit_div_reg <= bit_div_reg + 8'h01;
    end
  end

  // frame spacing register; writes accepted at any moment, take effect at next reload
  // bits 15:14 are not stored, so anything written there reads back as zero
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      interval_toggle_reg <= 1'b0;
      fs_max_packet_bits_reg <= 15'h0000;
      frame_interval_bits_reg <= `UFDQ_FI_RESET;
    end else if (wr_spacing) begin
      interval_toggle_reg <= reg_req.wdata[`UFDQ_FIT_BIT];
      fs_max_packet_bits_reg <= reg_req.wdata[`UFDQ_FS_MAX_PACKET_BITS_MSB:`UFDQ_FS_MAX_PACKET_BITS_LSB];
      frame_interval_bits_reg <= reg_req.wdata[`UFDQ_FI_MSB:`UFDQ_FI_LSB];
    end
  end

  // frame countdown; only runs while operational
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      frame_remaining_count_reg <= 14'h0000;
      remaining_toggle_reg <= 1'b0;
      oper_d_reg <= 1'b0;
      sof_reg <= 1'b0;
    end else begin
      oper_d_reg <= operational_state;
      sof_reg <= 1'b0;
      // entry restarts the frame at once; a count left from before a stop is never used
      if (oper_rise) begin
        frame_remaining_count_reg <= frame_interval_bits_reg;
        sof_reg <= 1'b1;
      end else if (operational_state && bit_tick) begin
        if (frame_zero) begin
          frame_remaining_count_reg <= frame_interval_bits_reg;
          // toggle moves only at a boundary, so software can tell when its interval took hold
          remaining_toggle_reg <= interval_toggle_reg;
          sof_reg <= 1'b1;
        end else begin
          frame_remaining_count_reg <= frame_remaining_count_reg - 14'h0001;
        end
      end
    end
  end

  // largest-packet budget: loaded at frame start, worn down by elapsed bit time
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      budget_reg <= 15'h0000;
    end else if (sof_reg) begin
      budget_reg <= fs_max_packet_bits_reg;
    // floors at zero instead of wrapping, so an exhausted frame grants only zero-bit requests
    end else if (bit_tick && budget_reg != 15'h0000) begin
      budget_reg <= budget_reg - 15'h0001;
    end
  end

  assign budget_bits = budget_reg;
  // combinational so a request is answered in the cycle it is raised
  assign xact_grant = xact_req && (xact_bits <= budget_reg);
  // one clock wide, marks each frame start including the entry frame
  assign sof_pulse = sof_reg;

  // done-queue sequencer: one memory write per step, waits for mem_ack
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_reg <= UFDQ_IDLE;
      mem_reg <= '0;
      pend_addr_reg <= 32'h00000000;
      done_queue_head_ptr_reg <= 28'h0000000;
    end else begin
      case (state_reg)
        UFDQ_IDLE: begin
          // completions go before a flush; a flush waiting behind one sees the new head
          if (td_done) begin
            // link word is the descriptor's first dword
            mem_reg <= '{1'b1, td_addr, ufdq_head_word(done_queue_head_ptr_reg)};
            pend_addr_reg <= td_addr;
            state_reg <= UFDQ_LINK;
          end else if (flush_req) begin
            mem_reg <= '{1'b1, SHARED_HEAD_ADDR,
                         ufdq_head_word(done_queue_head_ptr_reg)};
            state_reg <= UFDQ_FLUSH;
          end else if (wr_head) begin
            // a head write that meets a completion or flush is dropped, never merged
            done_queue_head_ptr_reg <= ufdq_head_field(reg_req.wdata);
          end
        end
        UFDQ_LINK: begin
          // the head moves only once the link word is in memory, so a stalled write
          // never leaves software a queue whose newest entry is not yet linked
          if (mem_ack) begin
            mem_reg <= '0;
            done_queue_head_ptr_reg <= ufdq_head_field(pend_addr_reg);
            state_reg <= UFDQ_IDLE;
          end
        end
        UFDQ_FLUSH: begin
          // cleared only after the shared copy is written, so the head is never lost
          if (mem_ack) begin
            mem_reg <= '0;
            done_queue_head_ptr_reg <= 28'h0000000;
            state_reg <= UFDQ_IDLE;
          end
        end
        default: begin
          state_reg <= UFDQ_IDLE;
        end
      endcase
    end
  end

  assign td_ready = (state_reg == UFDQ_IDLE);
  assign mem_wr = mem_reg;

  // reserved fields are packed as constant zero so reads never show stale write data
  assign spacing_word = {interval_toggle_reg, fs_max_packet_bits_reg, 2'b00,
                         frame_interval_bits_reg};
  assign countdown_word = {remaining_toggle_reg, 17'h00000, frame_remaining_count_reg};

  // register read data, registered; reserved bits read zero
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_req.rd) begin
      case (reg_req.addr)
        `UFDQ_DONE_HEAD_OFS: reg_rdata <= ufdq_head_word(done_queue_head_ptr_reg);
        `UFDQ_FRAME_SPACING_OFS: reg_rdata <= spacing_word;
        `UFDQ_FRAME_COUNTDOWN_OFS: reg_rdata <= countdown_word;
        default: reg_rdata <= 32'h00000000;
      endcase
    end
  end
endmodule

// ---- verification/ufdq_top_assertions.sv ----
// assertion checker for the frame/done-queue block ports
`timescale 1ns/10ps
module ufdq_assertions import ufdq_pkg::*; #(
  parameter logic [31:0] SHARED_HEAD_ADDR = 32'h00000084
) (
  input logic clock,
  input logic rst_n,
  input ufdq_regreq_s reg_req,
  input logic [31:0] reg_rdata,
  input logic td_done,
  input logic [31:0] td_addr,
  input logic td_ready,
  input logic flush_req,
  input ufdq_memwr_s mem_wr,
  input logic mem_ack,
  input logic [14:0] xact_bits,
  input logic xact_req,
  input logic xact_grant,
  input logic sof_pulse,
  input logic [14:0] budget_bits
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence head_rd;
    reg_req.rd && reg_req.addr == 8'h30;
  endsequence
  link_addr_a: assert property (td_ready && td_done |=>
    mem_wr.valid && mem_wr.addr == $past(td_addr)) else $error("link address");
  flush_addr_a: assert property (td_ready && !td_done && flush_req |=>
    mem_wr.valid && mem_wr.addr == SHARED_HEAD_ADDR) else $error("flush address");
  grant_rule_a: assert property (xact_grant ==
    (xact_req && xact_bits <= budget_bits)) else $error("grant");
  write_hold_a: assert property (mem_wr.valid && !mem_ack |=>
    mem_wr.valid && $stable(mem_wr)) else $error("write dropped");
  ack_drop_a: assert property (mem_wr.valid && mem_ack |=>
    !mem_wr.valid && td_ready) else $error("ack");
  busy_ready_a: assert property (mem_wr.valid |->
    !td_ready) else $error("ready while busy");
  budget_grow_a: assert property (budget_bits > $past(budget_bits) |->
    $past(sof_pulse)) else $error("budget grew");
  head_rsvd_a: assert property (head_rd |=>
    reg_rdata[3:0] == 4'h0) else $error("head low bits");
endmodule
bind ufdq_top ufdq_assertions #(.SHARED_HEAD_ADDR(SHARED_HEAD_ADDR)) chk_i (.*);

// ---- verification/tb_ufdq_top.sv ----
// self-checking bench for the frame/done-queue block
`timescale 1ns/10ps
module tb_ufdq_top import ufdq_pkg::*; ();
  localparam logic [31:0] shared_addr = 32'h00000084;
  logic clock = 0, rst_n = 0, operational_state = 0, td_done = 0, flush_req = 0;
  logic mem_ack = 0, xact_req = 0, td_ready, xact_grant, sof_pulse;
  logic [31:0] td_addr = 0, reg_rdata;
  logic [14:0] xact_bits = 0, budget_bits;
  ufdq_regreq_s reg_req = '0;
  ufdq_memwr_s mem_wr;
  int mismatches = 0, checks_done = 0, cyc = 0, n;
  ufdq_top #(.BIT_CYCLES(5), .SHARED_HEAD_ADDR(shared_addr)) dut (.*);
  initial forever #10 clock = ~clock;
  task automatic results;
    if (mismatches == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, e);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock) #1 reg_req = '{1'b1, 1'b0, a, d};
    @(posedge clock) #1 reg_req = '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, e);
    @(posedge clock) #1 reg_req = '{1'b0, 1'b1, a, 32'h00000000};
    @(posedge clock) #1 reg_req = '0;
    chk(reg_rdata & m, e);
  endtask
  // memory side stalls two cycles so the held request is exercised
  task automatic xfer(input logic d, f, input logic [31:0] a, ea, ed);
    @(posedge clock) #1 {td_done, flush_req, td_addr} = {d, f, a};
    @(posedge clock) #1 {td_done, flush_req} = 2'b00;
    chk({31'h0, mem_wr.valid}, 32'h00000001);
    chk({31'h0, td_ready}, 32'h00000000);
    chk(mem_wr.addr, ea);
    chk(mem_wr.data, ed);
    repeat (2) @(posedge clock);
    #1 mem_ack = 1;
    @(posedge clock) #1 mem_ack = 0;
  endtask
  task automatic wsof(output int k);
    k = 0;
    do begin
      @(posedge clock) #1 k++;
    end while (sof_pulse !== 1'b1 && k < 400);
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc > 2000) begin
      mismatches++;
      results();
    end
  end
  initial begin
    repeat (3) @(posedge clock);
    #1 rst_n = 1;
    rd(8'h34, '1, 32'h00002EDF);
    rd(8'h30, '1, 32'h00000000);
    rd(8'h3C, '1, 32'h00000000);
    wr(8'h30, 32'hFFFFFFF0);
    rd(8'h30, '1, 32'hFFFFFFF0);
    wr(8'h30, 32'h00001230);
    xfer(1, 0, 32'h0000A5A0, 32'h0000A5A0, 32'h00001230);
    rd(8'h30, '1, 32'h0000A5A0);
    xfer(0, 1, 32'h00000000, shared_addr, 32'h0000A5A0);
    rd(8'h30, '1, 32'h00000000);
    wr(8'h34, 32'h80400003);
    rd(8'h34, '1, 32'h80400003);
    operational_state = 1;
    wsof(n);
    chk(n, 1);
    // the first frame may be cut short by the free bit tick, so skip it
    wsof(n);
    wsof(n);
    chk(n, 20);
    @(posedge clock) #1 {xact_req, xact_bits} = {1'b1, 15'h0041};
    @(negedge clock);
    chk({17'h0, budget_bits}, 32'h00000040);
    chk({31'h0, xact_grant}, 32'h00000000);
    @(posedge clock) #1 xact_bits = 15'h0040;
    @(negedge clock);
    chk({31'h0, xact_grant}, 32'h00000001);
    // first bit tick of the frame has worn one bit off the budget
    repeat (4) @(posedge clock);
    #1 chk({17'h0, budget_bits}, 32'h0000003F);
    chk({31'h0, xact_grant}, 32'h00000000);
    xact_req = 0;
    rd(8'h38, 32'h80000000, 32'h80000000);
    wr(8'h34, 32'h00400005);
    // new toggle must not reach the countdown before the frame ends
    rd(8'h38, 32'h80000000, 32'h80000000);
    repeat (2) wsof(n);
    wsof(n);
    chk(n, 30);
    rd(8'h38, 32'h80000000, 32'h00000000);
    // read back the interval, reset mid-run, then write it again with the toggle flipped
    rd(8'h34, '1, 32'h00400005);
    rst_n = 0;
    operational_state = 0;
    repeat (3) @(posedge clock);
    #1 rst_n = 1;
    rd(8'h34, '1, 32'h00002EDF);
    rd(8'h38, '1, 32'h00000000);
    wr(8'h34, 32'h80400005);
    rd(8'h34, '1, 32'h80400005);
    results();
  end
endmodule
